// ---- dcpt_timer.sv ----
// Behaviour
// - Sixteen-bit counter, decrement only
// - Compare output follows selected relation
// - Reload period on start, reset, expiry
// - Interrupt from expiry, compare, capture selectable
// - Free run, one-shot or enable-gated
// - One-shot stops after one period
// - Gated mode counts only while enabled
// - Compare, expiry/complement and interrupt outputs
// - Kill forces compare outputs inactive
// - True and complement PWM with deadband
// - Capture stores full counter value
// - Count clock source selectable
`timescale 1ns/100ps
module dcpt_timer
  import dcpt_pkg::*;
#(
  parameter int DEAD_W = 8,
  parameter int DIV_W = 16
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic ext_clk, // External count clock
  input wire logic tmr_enable, // Count enable input
  input wire logic tmr_reset, // Period reload request
  input wire logic tmr_capture, // Capture request
  input wire logic tmr_kill, // Output kill
  output logic cmp_out, // Compare output
  output logic count_expired_flag, // Expiry or complement
  output logic irq // Interrupt request
);
  import dcpt_pkg::*;

  initial begin
    if (DEAD_W < 1 || DEAD_W > 16 || DIV_W < 1 || DIV_W > 16) begin
      $error("dcpt_timer: unsupported parameter value");
    end
  end

  logic [31:0] ctrl_r;
  logic [CNT_W-1:0] period_r;
  logic [CNT_W-1:0] cmpval_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] capt_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  logic [DEAD_W-1:0] dead_r;
  logic [DIV_W-1:0] clkdiv_r;
  logic [DIV_W-1:0] divcnt_r;
  logic div_tick_r;
  logic ext_prev_r;
  logic running_r;
  logic en_prev_r;
  logic cap_prev_r;
  logic rst_prev_r;
  logic tc_r;
  logic cmp_raw;
  logic tick;
  logic [3:0] sync_q;
  logic ext_s;
  logic en_s;
  logic rst_s;
  logic cap_s;
  logic kill_s;
  logic start;
  logic rst_evt;
  logic cap_evt;
  logic cmp_rise;
  logic tc_evt;
  logic cnt_en;
  logic pwm_t;
  logic pwm_c;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic addr_ok;
  dcpt_mode_e mode;
  dcpt_rel_e rel;
  dcpt_clk_e csel;
  logic cmp_r;
  logic db_t_out;

  assign mode = dcpt_mode_e'(ctrl_r[CTRL_MODE_LO +: 2]);
  assign rel = dcpt_rel_e'(ctrl_r[CTRL_REL_LO +: 3]);
  assign csel = dcpt_clk_e'(ctrl_r[CTRL_CLK_LO +: 2]);

  // Routed inputs are asynchronous to pclk
  dcpt_sync #(.W(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({tmr_kill, tmr_capture, tmr_reset, tmr_enable, ext_clk}),
    .q({kill_s, sync_q})
  );
  assign {cap_s, rst_s, en_s, ext_s} = sync_q;

  // Divider for the slower internal count source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divcnt_r <= '0;
      div_tick_r <= 1'b0;
    end else if (divcnt_r >= clkdiv_r) begin
      divcnt_r <= '0;
      div_tick_r <= 1'b1;
    end else begin
      divcnt_r <= divcnt_r + 1'b1;
      div_tick_r <= 1'b0;
    end
  end

  // Edge history for routed ext, reload and capture inputs and the enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_r <= 1'b0;
      rst_prev_r <= 1'b0;
      cap_prev_r <= 1'b0;
      en_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_s;
      rst_prev_r <= rst_s;
      cap_prev_r <= cap_s;
      en_prev_r <= ctrl_r[CTRL_EN];
    end
  end

  always_comb begin
    case (csel)
      CLK_BUS: tick = 1'b1;
      CLK_DIV: tick = div_tick_r;
      CLK_EXT: tick = ext_s & ~ext_prev_r;
      default: tick = 1'b0;
    endcase
  end

  // Reload and capture on rising edges of routed inputs
  assign rst_evt = rst_s & ~rst_prev_r;
  assign cap_evt = cap_s & ~cap_prev_r;
  assign start = ctrl_r[CTRL_EN] & ~en_prev_r;
  assign cnt_en = running_r & tick & ctrl_r[CTRL_EN] &
                  ((mode != MODE_GATED) | en_s);
  assign tc_evt = cnt_en & (count_r == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= PERIOD_RST;
    end else if (start || rst_evt) begin
      count_r <= period_r;
    end else if (tc_evt) begin
      count_r <= period_r;
    end else if (cnt_en) begin
      count_r <= count_r - 1'b1;
    end
  end

  // One-shot stops at end of period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_r <= 1'b0;
    end else if (!ctrl_r[CTRL_EN]) begin
      running_r <= 1'b0;
    end else if (start || rst_evt) begin
      running_r <= 1'b1;
    end else if (tc_evt && mode == MODE_ONESHOT) begin
      running_r <= 1'b0;
    end
  end

  // Expiry level lasts one count clock at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_r <= 1'b0;
    end else if (tick || !running_r) begin
      tc_r <= tc_evt;
    end
  end

  always_comb begin
    case (rel)
      cmp_less: cmp_raw = count_r < cmpval_r;
      cmp_less_or_equal: cmp_raw = count_r <= cmpval_r;
      cmp_equal: cmp_raw = count_r == cmpval_r;
      cmp_greater_or_equal: cmp_raw = count_r >= cmpval_r;
      cmp_greater: cmp_raw = count_r > cmpval_r;
      default: cmp_raw = 1'b0;
    endcase
  end

  assign pwm_t = cmp_raw & ~kill_s;
  assign pwm_c = ~cmp_raw & ~kill_s;

  // Rising edges of both outputs delayed
  dcpt_deadband #(.DW(DEAD_W)) u_db_t (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .dead(dead_r),
    .in(pwm_t),
    .out(db_t_out)
  );
  logic comp_out;
  dcpt_deadband #(.DW(DEAD_W)) u_db_c (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .dead(dead_r),
    .in(pwm_c),
    .out(comp_out)
  );

  // Both outputs retimed alike so the deadband gap stays even
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_out <= 1'b0;
      count_expired_flag <= 1'b0;
    end else begin
      cmp_out <= db_t_out;
      count_expired_flag <= ctrl_r[CTRL_TCSEL] ? comp_out : tc_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capt_r <= '0;
    end else if (cap_evt) begin
      capt_r <= count_r;
    end
  end

  // APB decode; zero wait states
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      OFF_CTRL: rdata = ctrl_r;
      OFF_PERIOD: rdata = {16'h0000, period_r};
      OFF_CMP: rdata = {16'h0000, cmpval_r};
      OFF_COUNT: rdata = {16'h0000, count_r};
      OFF_CAPT: rdata = {16'h0000, capt_r};
      OFF_STAT: rdata = {29'h0, stat_r};
      OFF_MASK: rdata = {29'h0, mask_r};
      OFF_DEAD: rdata = {{(32-DEAD_W){1'b0}}, dead_r};
      OFF_CLKDIV: rdata = {{(32-DIV_W){1'b0}}, clkdiv_r};
      default: begin
        rdata = 32'h0000_0000;
        addr_ok = 1'b0;
      end
    endcase
  end

  // Read data registered in setup so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= rd ? rdata : 32'h0000_0000;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      period_r <= PERIOD_RST;
      cmpval_r <= CMP_RST;
      mask_r <= 3'h0;
      dead_r <= DEAD_W'(DEAD_RST);
      clkdiv_r <= DIV_W'(CLKDIV_RST);
    end else if (wr) begin
      case (paddr)
        OFF_CTRL: ctrl_r <= {23'h0, pwdata[8:0]};
        OFF_PERIOD: period_r <= pwdata[15:0];
        OFF_CMP: cmpval_r <= pwdata[15:0];
        OFF_MASK: mask_r <= pwdata[2:0];
        OFF_DEAD: dead_r <= pwdata[DEAD_W-1:0];
        OFF_CLKDIV: clkdiv_r <= pwdata[DIV_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a set wins over a write-one clear
  assign cmp_rise = pwm_t & ~cmp_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_r <= 1'b0;
      stat_r <= 3'h0;
    end else begin
      cmp_r <= pwm_t;
      stat_r <= (stat_r & ~((wr && paddr == OFF_STAT) ? pwdata[2:0] : 3'h0))
                | {cap_evt, cmp_rise, tc_evt};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_r & mask_r);
    end
  end
endmodule

// ---- dcpt_pkg.sv ----
package dcpt_pkg;
  // Counter width
  localparam int CNT_W = 16;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PERIOD = 12'h004;
  localparam logic [11:0] OFF_CMP = 12'h008;
  localparam logic [11:0] OFF_COUNT = 12'h00c;
  localparam logic [11:0] OFF_CAPT = 12'h010;
  localparam logic [11:0] OFF_STAT = 12'h014;
  localparam logic [11:0] OFF_MASK = 12'h018;
  localparam logic [11:0] OFF_DEAD = 12'h01c;
  localparam logic [11:0] OFF_CLKDIV = 12'h020;
  // Control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_REL_LO = 3;
  localparam int CTRL_CLK_LO = 6;
  localparam int CTRL_TCSEL = 8;
  // Status / mask bit positions
  localparam int ST_TC = 0;
  localparam int ST_CMP = 1;
  localparam int ST_CAP = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [7:0] DEAD_RST = 8'h00;
  localparam logic [15:0] CLKDIV_RST = 16'h0000;
  // Counting modes
  typedef enum logic [1:0] {
    MODE_FREE,
    MODE_ONESHOT,
    MODE_GATED,
    MODE_RSVD
  } dcpt_mode_e;
  // Compare relations
  typedef enum logic [2:0] {
    cmp_less,
    cmp_less_or_equal,
    cmp_equal,
    cmp_greater_or_equal,
    cmp_greater
  } dcpt_rel_e;
  // Count clock sources
  typedef enum logic [1:0] {
    CLK_BUS,
    CLK_DIV,
    CLK_EXT
  } dcpt_clk_e;
endpackage

// ---- dcpt_sync.sv ----
`timescale 1ns/100ps
module dcpt_sync #(
  parameter int W = 1
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  logic [W-1:0] meta_r;
  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ---- dcpt_deadband.sv ----
`timescale 1ns/100ps
module dcpt_deadband #(
  parameter int DW = 8
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic tick, // Count clock enable
  input wire logic [DW-1:0] dead, // Deadband in count clocks
  input wire logic in, // Raw drive level
  output logic out // Drive with delayed rise
);
  logic [DW-1:0] cnt_r;
  // Falling edges pass at once, rising edges wait out the deadband
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      out <= 1'b0;
    end else if (!in) begin
      cnt_r <= '0;
      out <= 1'b0;
    end else if (!out && tick) begin
      if (cnt_r >= dead) begin
        out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// ---- dcpt_timer_properties.sv ----
`timescale 1ns/100ps
module dcpt_timer_properties
  import dcpt_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic ext_clk, // Ext clock
  input wire logic tmr_enable, // Gate
  input wire logic tmr_reset, // Reload
  input wire logic tmr_capture, // Capture
  input wire logic tmr_kill, // Kill
  input wire logic cmp_out, // Compare
  input wire logic count_expired_flag, // Expiry
  input wire logic irq // Interrupt
);
  logic [8:0] ctrl_r;
  logic per_z_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow control and zero period; a zero period keeps expiry high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 9'h000;
      per_z_r <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == OFF_CTRL) ctrl_r <= pwdata[8:0];
      if (paddr == OFF_PERIOD) per_z_r <= (pwdata[15:0] == 16'h0000);
    end
  end
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_hold; pready |-> psel && penable; endproperty
  a_hold: assert property (p_hold) else $error("ready outside access");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_map; psel && !penable && paddr > OFF_CLKDIV |=> pslverr;
  endproperty
  a_map: assert property (p_map) else $error("unmapped not refused");
  property p_kill;
    tmr_kill [*6] |-> !cmp_out && !(ctrl_r[8] && count_expired_flag);
  endproperty
  a_kill: assert property (p_kill) else $error("kill ignored");
  property p_dead;
    $past(ctrl_r[8]) && ctrl_r[8] |-> !(cmp_out && count_expired_flag);
  endproperty
  a_dead: assert property (p_dead) else $error("both active");
  property p_tc;
    $stable(ctrl_r) && ctrl_r[8:6] == 3'b000 && !per_z_r &&
      count_expired_flag |=> !count_expired_flag;
  endproperty
  a_tc: assert property (p_tc) else $error("expiry too long");
  c_kill: cover property (tmr_kill ##6 !cmp_out);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule
bind dcpt_timer dcpt_timer_properties dcpt_timer_properties_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .ext_clk, .tmr_enable, .tmr_reset, .tmr_capture,
  .tmr_kill, .cmp_out, .count_expired_flag, .irq);

// ---- dcpt_fabric.sv ----
`timescale 1ns/100ps
module dcpt_fabric (
  input wire logic pclk, // Clock
  output logic ext_clk, // Ext count clock
  output logic tmr_enable, // Gate
  output logic tmr_reset, // Reload request
  output logic tmr_capture, // Capture request
  output logic tmr_kill // Kill
);
  // Idle levels; ext clock stands still until asked
  initial begin
    ext_clk = 1'b0;
    tmr_enable = 1'b0;
    tmr_reset = 1'b0;
    tmr_capture = 1'b0;
    tmr_kill = 1'b0;
  end
  // Reload or capture
  // Held four cycles so the two-flop sync cannot miss it
  task automatic pulse(input int cap);
    @(posedge pclk);
    tmr_capture <= (cap != 0);
    tmr_reset <= (cap == 0);
    repeat (4) @(posedge pclk);
    tmr_reset <= 1'b0;
    tmr_capture <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // Slow ext clock, four bus cycles a phase
  task automatic ext_ticks(input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge pclk);
      ext_clk <= ~ext_clk;
    end
  endtask
  // Gate window of n cycles
  task automatic gate(input int n);
    @(posedge pclk);
    tmr_enable <= 1'b1;
    repeat (n) @(posedge pclk);
    tmr_enable <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic kill(input logic v);
    @(posedge pclk);
    tmr_kill <= v;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// ---- dcpt_timer_tb_top.sv ----
`timescale 1ns/100ps
module dcpt_timer_tb_top;
  import dcpt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ext_clk, tmr_enable, tmr_reset, tmr_capture, tmr_kill;
  logic cmp_out, count_expired_flag, irq;
  logic [31:0] exp_q[$];
  logic [15:0] per, c;
  int bad_count = 0;
  int n_tests = 0;
  int seed = 92534;
  int cyc = 0;
  int i, n;
  dcpt_timer dcpt_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_clk, .tmr_enable,
    .tmr_reset, .tmr_capture, .tmr_kill, .cmp_out, .count_expired_flag,
    .irq);
  dcpt_fabric dcpt_fabric_inst (.pclk, .ext_clk, .tmr_enable, .tmr_reset,
    .tmr_capture, .tmr_kill);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus cycle: setup, then access held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [31:0] ctl(input int m, r, k, t);
    return {23'h0, t[0], k[1:0], r[2:0], m[1:0], 1'b1};
  endfunction
  function automatic logic relf(input int r, input logic [15:0] a, b);
    case (r)
      0: return a < b;
      1: return a <= b;
      2: return a == b;
      3: return a >= b;
      default: return a > b;
    endcase
  endfunction
  // Read checker takes the oldest expectation at each answered read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk(prdata, exp_q.pop_front());
    end
  end
  // Hang guard, well above the sequence length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_PERIOD, {16'h0, PERIOD_RST});
    rd(OFF_COUNT, 32'h0000ffff);
    rd(12'h024, 32'h0);
    $display("test reset done");
    per = $random(seed);
    per[15] = 1'b1;
    wr(OFF_PERIOD, {16'h0, per});
    wr(OFF_CTRL, ctl(MODE_GATED, cmp_less, CLK_BUS, 0));
    rd(OFF_COUNT, {16'h0, per});
    dcpt_fabric_inst.pulse(1);
    rd(OFF_CAPT, {16'h0, per});
    dcpt_fabric_inst.gate(7);
    c = per - 16'd7;
    rd(OFF_COUNT, {16'h0, c});
    $display("test gated done");
    for (n = 0; n < 2; n++) begin
      wr(OFF_CMP, {16'h0, c + n[15:0]});
      for (i = 0; i < 5; i++) begin
        wr(OFF_CTRL, ctl(MODE_GATED, i, CLK_BUS, 0));
        repeat (8) @(posedge pclk);
        chk(cmp_out, relf(i, c, c + n[15:0]));
      end
    end
    // Make the compare true so the kill has something to override
    wr(OFF_CTRL, ctl(MODE_GATED, cmp_less, CLK_BUS, 0));
    dcpt_fabric_inst.kill(1'b1);
    chk(cmp_out, 0);
    dcpt_fabric_inst.kill(1'b0);
    chk(cmp_out, 1);
    wr(OFF_DEAD, 32'h4);
    wr(OFF_CTRL, ctl(MODE_GATED, cmp_greater, CLK_BUS, 1));
    repeat (12) @(posedge pclk);
    chk({cmp_out, count_expired_flag}, 2'b01);
    wr(OFF_CTRL, ctl(MODE_GATED, cmp_less, CLK_BUS, 1));
    n = 0;
    repeat (30) begin
      @(posedge pclk);
      if (!cmp_out && !count_expired_flag) n++;
    end
    chk(n >= 4 && n <= 5, 1);
    chk({cmp_out, count_expired_flag}, 2'b10);
    $display("test compare done");
    wr(OFF_DEAD, 32'h0);
    wr(OFF_CMP, 32'h0);
    wr(OFF_PERIOD, 32'h3);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STAT, 32'h7);
    wr(OFF_MASK, 32'h1);
    wr(OFF_CTRL, ctl(MODE_ONESHOT, cmp_less, CLK_BUS, 0));
    for (i = 0; i < 50 && count_expired_flag !== 1'b1; i++) @(posedge pclk);
    chk(count_expired_flag, 1);
    n = 0;
    repeat (30) begin
      @(posedge pclk);
      if (count_expired_flag === 1'b1) n++;
    end
    chk(n, 0);
    rd(OFF_STAT, 32'h1);
    chk(irq, 1);
    wr(OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    wr(OFF_MASK, 32'h1);
    wr(OFF_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    $display("test oneshot done");
    wr(OFF_PERIOD, {16'h0, per});
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, ctl(MODE_FREE, cmp_less, CLK_EXT, 0));
    dcpt_fabric_inst.ext_ticks(5);
    repeat (6) @(posedge pclk);
    rd(OFF_COUNT, {16'h0, per - 16'd5});
    dcpt_fabric_inst.pulse(0);
    rd(OFF_COUNT, {16'h0, per});
    // Divided source: reload and capture lie 11 edges apart, one tick
    wr(OFF_CLKDIV, 32'h9);
    wr(OFF_CTRL, ctl(MODE_FREE, cmp_less, CLK_DIV, 0));
    dcpt_fabric_inst.pulse(0);
    dcpt_fabric_inst.pulse(1);
    rd(OFF_CAPT, {16'h0, per - 16'd1});
    $display("test clock done");
    give_verdict();
  end
endmodule
